/* File: hw/iod_pkg.sv */
package iod_pkg;

    localparam int NREG = 21;

    // data-space layout
    localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
    localparam logic [7:0] LOW_BASE       = 8'h20;
    localparam logic [7:0] LOW_TOP        = 8'h3f;
    localparam logic [7:0] EXT_BASE       = 8'h60;
    localparam logic [7:0] BYTE_MASK      = 8'hff;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;

    // register indices
    localparam int IDX_SPI_DATA   = 0;
    localparam int IDX_COMP_CS    = 1;
    localparam int IDX_SLEEP      = 2;
    localparam int IDX_RST_CAUSE  = 3;
    localparam int IDX_CORE_CTL   = 4;
    localparam int IDX_SELF_PROG  = 5;
    localparam int IDX_SP_LOW     = 6;
    localparam int IDX_SP_HIGH    = 7;
    localparam int IDX_STATUS     = 8;
    localparam int IDX_WDOG       = 9;
    localparam int IDX_FIRST_EXT  = 9;

    // field positions
    localparam int COMP_EVENT_BIT = 4;
    localparam int COMP_OUT_BIT   = 5;
    localparam int PROG_BUSY_BIT  = 6;
    localparam int WDOG_EVENT_BIT = 7;

    // data-space offsets in table order
    localparam logic [7:0] REG_OFFSET [NREG] = '{
        8'h4e, 8'h50, 8'h53, 8'h54, 8'h55, 8'h57, 8'h5d, 8'h5e, 8'h5f, 8'h60,
        8'h61, 8'h64, 8'h66, 8'h68, 8'h69, 8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h6f,
        8'h70};

    // bits that software reads and writes plainly
    localparam logic [7:0] REG_RW_MASK [NREG] = '{
        8'hff, 8'hcf, 8'h0f, 8'h0f, 8'h13, 8'h9f, 8'hff, 8'h07, 8'hff, 8'h7f,
        8'h8f, 8'hef, 8'hff, 8'h07, 8'h0f, 8'hff, 8'h7f, 8'hff, 8'h07, 8'h27,
        8'h07};

    // flags cleared by writing one
    localparam logic [7:0] REG_W1C_MASK [NREG] = '{
        8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00};

    // bits that only mirror live hardware state
    localparam logic [7:0] REG_RO_MASK [NREG] = '{
        8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00};

    localparam logic [7:0] REG_RESET = 8'h00;

endpackage

/* File: hw/iod_flag_reg.sv */
module iod_flag_reg #(
    parameter logic [7:0] RW_MASK  = 8'hff,
    parameter logic [7:0] W1C_MASK = 8'h00,
    parameter logic [7:0] RO_MASK  = 8'h00
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // byte write
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    // hardware side
    input  wire logic [7:0] hwSet,
    input  wire logic [7:0] roVal,
    // state
    output logic      [7:0] q,
    output logic      [7:0] rdVal
);
    logic [7:0] next_q;
    logic [7:0] clrBits;

    always_comb begin
        clrBits = wrEn ? wrData : iod_pkg::ZERO_BYTE;
        // reserved bits never store
        next_q = ((wrEn ? wrData : q) & RW_MASK)
               | (q & W1C_MASK & ~clrBits)
               | (hwSet & (RW_MASK | W1C_MASK));
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= iod_pkg::REG_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign rdVal = (q & (RW_MASK | W1C_MASK)) | (roVal & RO_MASK);

endmodule // iod_flag_reg

/* File: hw/iod_access_decode.sv */
module iod_access_decode (
    // short i/o access
    input  wire logic       ioRdEn,
    input  wire logic       ioWrEn,
    input  wire logic [5:0] ioAddr,
    // single-bit access
    input  wire logic       setIoBitEn,
    input  wire logic       clearIoBitEn,
    input  wire logic       testIoBitEn,
    input  wire logic [4:0] bitAddr,
    input  wire logic [2:0] bitSel,
    // data-space access
    input  wire logic       dataRdEn,
    input  wire logic       dataWrEn,
    input  wire logic [7:0] dataAddr,
    input  wire logic [7:0] wrData,
    // unified access
    output logic            accRead,
    output logic            accWrite,
    output logic            accTest,
    output logic      [7:0] accAddr,
    output logic      [7:0] accData,
    output logic      [7:0] accMask
);
    function automatic logic [7:0] ioToData(input logic [5:0] a);
        ioToData = {2'b00, a} + iod_pkg::IO_DATA_OFFSET;
    endfunction

    always_comb begin
        accRead  = 1'b0;
        accWrite = 1'b0;
        accTest  = 1'b0;
        accAddr  = iod_pkg::ZERO_BYTE;
        accData  = wrData;
        accMask  = iod_pkg::BYTE_MASK;
        if (dataRdEn || dataWrEn) begin
            accRead  = dataRdEn;
            accWrite = dataWrEn && !dataRdEn;
            accAddr  = dataAddr;
        end else if (ioRdEn || ioWrEn) begin
            accRead  = ioRdEn;
            accWrite = ioWrEn && !ioRdEn;
            accAddr  = ioToData(ioAddr);
        end else if (setIoBitEn || clearIoBitEn || testIoBitEn) begin
            // bit address is five bits wide, so only the low range is reachable
            accAddr  = ioToData({1'b0, bitAddr});
            accTest  = testIoBitEn && !setIoBitEn && !clearIoBitEn;
            accWrite = setIoBitEn || clearIoBitEn;
            accMask  = 8'h01 << bitSel;
            accData  = setIoBitEn ? iod_pkg::BYTE_MASK : iod_pkg::ZERO_BYTE;
        end
    end

endmodule // iod_access_decode

/* File: hw/io_register_space_decoder.sv */
module io_register_space_decoder (
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       srst,
    // short i/o requests
    input  wire logic                       ioRdEn,
    input  wire logic                       ioWrEn,
    input  wire logic [5:0]                 ioAddr,
    // single-bit requests
    input  wire logic                       setIoBitEn,
    input  wire logic                       clearIoBitEn,
    input  wire logic                       testIoBitEn,
    input  wire logic [4:0]                 bitAddr,
    input  wire logic [2:0]                 bitSel,
    // data-space requests
    input  wire logic                       dataRdEn,
    input  wire logic                       dataWrEn,
    input  wire logic [7:0]                 dataAddr,
    input  wire logic [7:0]                 wrData,
    // answers to the core
    output logic                            rdValid,
    output logic      [7:0]                 rdData,
    output logic                            bitValid,
    output logic                            bitValue,
    // low-range peripheral port
    output logic                            lowRdEn,
    output logic                            lowWrEn,
    output logic      [4:0]                 lowAddr,
    output logic      [7:0]                 lowWrData,
    output logic      [7:0]                 lowWrMask,
    input  wire logic [7:0]                 lowRdData,
    // hardware events and live state
    input  wire logic                       compEvent,
    input  wire logic                       compLevel,
    input  wire logic                       wdogEvent,
    input  wire logic [3:0]                 resetCause,
    input  wire logic                       progBusy,
    // register image
    output logic      [iod_pkg::NREG*8-1:0] ctlRegs
);
    logic             accRead;
    logic             accWrite;
    logic             accTest;
    logic [7:0]       accAddr;
    logic [7:0]       accData;
    logic [7:0]       accMask;
    logic             accLow;
    logic [7:0]       regQ   [iod_pkg::NREG];
    logic [7:0]       regRd  [iod_pkg::NREG];
    logic [7:0]       hwSet  [iod_pkg::NREG];
    logic [7:0]       roVal  [iod_pkg::NREG];
    logic [iod_pkg::NREG-1:0] regWrEn;
    // stage one of a read
    logic             pendRead;
    logic             pendTest;
    logic [7:0]       pendAddr;
    logic [2:0]       pendBit;
    logic [7:0]       next_rdData;

    iod_access_decode u_decode (
        .ioRdEn       (ioRdEn),
        .ioWrEn       (ioWrEn),
        .ioAddr       (ioAddr),
        .setIoBitEn   (setIoBitEn),
        .clearIoBitEn (clearIoBitEn),
        .testIoBitEn  (testIoBitEn),
        .bitAddr      (bitAddr),
        .bitSel       (bitSel),
        .dataRdEn     (dataRdEn),
        .dataWrEn     (dataWrEn),
        .dataAddr     (dataAddr),
        .wrData       (wrData),
        .accRead      (accRead),
        .accWrite     (accWrite),
        .accTest      (accTest),
        .accAddr      (accAddr),
        .accData      (accData),
        .accMask      (accMask)
    );

    assign accLow = (accAddr >= iod_pkg::LOW_BASE) && (accAddr <= iod_pkg::LOW_TOP);

    // hardware-set and mirrored bits
    always_comb begin
        for (int i = 0; i < iod_pkg::NREG; i++) begin
            hwSet[i] = iod_pkg::ZERO_BYTE;
            roVal[i] = iod_pkg::ZERO_BYTE;
        end
        hwSet[iod_pkg::IDX_COMP_CS][iod_pkg::COMP_EVENT_BIT] = compEvent;
        roVal[iod_pkg::IDX_COMP_CS][iod_pkg::COMP_OUT_BIT]   = compLevel;
        hwSet[iod_pkg::IDX_RST_CAUSE][3:0]                   = resetCause;
        roVal[iod_pkg::IDX_SELF_PROG][iod_pkg::PROG_BUSY_BIT] = progBusy;
        hwSet[iod_pkg::IDX_WDOG][iod_pkg::WDOG_EVENT_BIT]    = wdogEvent;
    end

    // byte writes only; bit writes never reach these offsets
    always_comb begin
        for (int i = 0; i < iod_pkg::NREG; i++) begin
            regWrEn[i] = accWrite && (accMask == iod_pkg::BYTE_MASK)
                       && (accAddr == iod_pkg::REG_OFFSET[i]);
        end
    end

    for (genvar g = 0; g < iod_pkg::NREG; g++) begin : g_reg
        iod_flag_reg #(
            .RW_MASK  (iod_pkg::REG_RW_MASK[g]),
            .W1C_MASK (iod_pkg::REG_W1C_MASK[g]),
            .RO_MASK  (iod_pkg::REG_RO_MASK[g])
        ) u_reg (
            .ref_clk (ref_clk),
            .srst    (srst),
            .wrEn    (regWrEn[g]),
            .wrData  (accData),
            .hwSet   (hwSet[g]),
            .roVal   (roVal[g]),
            .q       (regQ[g]),
            .rdVal   (regRd[g])
        );
        assign ctlRegs[g*8 +: 8] = regQ[g];
    end

    // low-range peripheral strobes
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lowRdEn   <= 1'b0;
            lowWrEn   <= 1'b0;
            lowAddr   <= 5'h00;
            lowWrData <= 8'h00;
            lowWrMask <= 8'h00;
        end else begin
            lowRdEn   <= (accRead || accTest) && accLow;
            lowWrEn   <= accWrite && accLow;
            lowAddr   <= 5'(accAddr - iod_pkg::LOW_BASE);
            lowWrData <= accData;
            lowWrMask <= accMask;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pendRead <= 1'b0;
            pendTest <= 1'b0;
            pendAddr <= 8'h00;
            pendBit  <= 3'h0;
        end else begin
            pendRead <= accRead;
            pendTest <= accTest;
            pendAddr <= accAddr;
            pendBit  <= bitSel;
        end
    end

    // read mux: unmapped locations answer zero
    always_comb begin
        next_rdData = iod_pkg::ZERO_BYTE;
        if ((pendAddr >= iod_pkg::LOW_BASE) && (pendAddr <= iod_pkg::LOW_TOP)) begin
            next_rdData = lowRdData;
        end
        for (int i = 0; i < iod_pkg::NREG; i++) begin
            if (pendAddr == iod_pkg::REG_OFFSET[i]) begin
                next_rdData = regRd[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdValid <= 1'b0;
            rdData  <= 8'h00;
        end else begin
            rdValid <= pendRead;
            rdData  <= pendRead ? next_rdData : rdData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bitValid <= 1'b0;
            bitValue <= 1'b0;
        end else begin
            bitValid <= pendTest;
            bitValue <= pendTest ? lowRdData[pendBit] : bitValue;
        end
    end

    // assertion helpers
    logic soleReq;
    assign soleReq = $onehot({ioRdEn, ioWrEn, setIoBitEn, clearIoBitEn, testIoBitEn,
                              dataRdEn, dataWrEn});

    a_bit_low_only: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && (setIoBitEn || clearIoBitEn)
        |-> (regWrEn == '0) ##1 (lowWrEn && ({3'b000, lowAddr} == $past(bitAddr))))
        else $error("bit write left the low range");

    a_bit_test_path: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && testIoBitEn |-> ##1 lowRdEn && !lowWrEn ##1 bitValid && !rdValid)
        else $error("bit test did not answer in two cycles");

    a_flag_w1c: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && dataWrEn && dataAddr == iod_pkg::REG_OFFSET[iod_pkg::IDX_COMP_CS]
        && !compEvent
        |=> regQ[iod_pkg::IDX_COMP_CS][iod_pkg::COMP_EVENT_BIT]
            == ($past(regQ[iod_pkg::IDX_COMP_CS][iod_pkg::COMP_EVENT_BIT])
                && !$past(wrData[iod_pkg::COMP_EVENT_BIT])))
        else $error("write-one-to-clear flag misbehaved");

    a_flag_set_wins: assert property (@(posedge ref_clk) disable iff (srst)
        wdogEvent |=> regQ[iod_pkg::IDX_WDOG][iod_pkg::WDOG_EVENT_BIT])
        else $error("flag event lost against clear");

    a_bit_mask_one: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && (setIoBitEn || clearIoBitEn)
        |=> lowWrMask == (8'h01 << $past(bitSel))
            && lowWrData == ($past(setIoBitEn) ? 8'hff : 8'h00))
        else $error("bit write touched more than one bit");

    a_io_read_lat: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && ioRdEn && ioAddr == 6'h3f
        |-> ##2 rdValid && rdData == $past(regQ[iod_pkg::IDX_STATUS], 2))
        else $error("short read of status register wrong");

    a_io_offset: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && ioWrEn && ioAddr == 6'h2e
        |=> regQ[iod_pkg::IDX_SPI_DATA] == $past(wrData))
        else $error("short write not mapped at plus 0x20");

    a_ext_data_only: assert property (@(posedge ref_clk) disable iff (srst)
        (ioWrEn || setIoBitEn || clearIoBitEn) && !dataWrEn && !dataRdEn
        |-> regWrEn[iod_pkg::NREG-1:iod_pkg::IDX_FIRST_EXT] == '0)
        else $error("extended register reached by short access");

    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && dataWrEn && dataAddr == iod_pkg::REG_OFFSET[iod_pkg::IDX_SP_HIGH]
        |=> regQ[iod_pkg::IDX_SP_HIGH][7:3] == 5'h00 ##1 !rdValid)
        else $error("reserved bits stored a value");

    a_reserved_read: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && dataRdEn && dataAddr == 8'h51 |-> ##2 rdValid && rdData == 8'h00)
        else $error("reserved location read nonzero");

    a_low_wr_map: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && ioWrEn && ioAddr < 6'h20
        |=> lowWrEn && lowAddr == $past(ioAddr[4:0]))
        else $error("short write missed the low range");

    a_low_rd_map: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && dataRdEn && dataAddr >= 8'h20 && dataAddr <= 8'h3f
        |=> lowRdEn && lowAddr == $past(dataAddr[4:0]))
        else $error("data read missed the low range");

    a_high_no_low: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && ioWrEn && ioAddr >= 6'h20
        |=> !lowWrEn)
        else $error("high short write leaked to low range");

    a_test_no_write: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && testIoBitEn
        |=> !lowWrEn && regWrEn == '0)
        else $error("bit test caused a write");

    a_test_value: assert property (@(posedge ref_clk) disable iff (srst)
        pendTest
        |=> bitValid && bitValue == $past(lowRdData[pendBit]))
        else $error("tested bit value wrong");

    a_w1c_keep: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && dataWrEn && dataAddr == iod_pkg::REG_OFFSET[iod_pkg::IDX_WDOG]
        && !wrData[iod_pkg::WDOG_EVENT_BIT] && !wdogEvent
        |=> regQ[iod_pkg::IDX_WDOG][7] == $past(regQ[iod_pkg::IDX_WDOG][7]))
        else $error("written zero changed a flag");

    a_bit_spares_regs: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && (setIoBitEn || clearIoBitEn) && !compEvent && !wdogEvent
        && resetCause == 4'h0
        |=> ctlRegs == $past(ctlRegs))
        else $error("bit write disturbed a mapped register");

    a_ext_write_map: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && dataWrEn && dataAddr == iod_pkg::REG_OFFSET[iod_pkg::IDX_WDOG]
        |=> regQ[iod_pkg::IDX_WDOG][6:0] == $past(wrData[6:0]))
        else $error("data store missed extended register");

    a_short_no_ext: assert property (@(posedge ref_clk) disable iff (srst)
        soleReq && ioRdEn
        |=> pendAddr < iod_pkg::EXT_BASE)
        else $error("short read reached extended space");

    a_rd_hold: assert property (@(posedge ref_clk) disable iff (srst)
        !pendRead
        |=> rdData == $past(rdData))
        else $error("read data moved without a read");

    a_rsv_bits_read: assert property (@(posedge ref_clk) disable iff (srst)
        rdValid && $past(pendAddr) == iod_pkg::REG_OFFSET[iod_pkg::IDX_SP_HIGH]
        |-> rdData[7:3] == 5'h00)
        else $error("reserved bits read nonzero");

    c_bit_set:   cover property (@(posedge ref_clk) soleReq && setIoBitEn ##1 lowWrEn);
    c_flag_clr:  cover property (@(posedge ref_clk)
        soleReq && dataWrEn && wrData[iod_pkg::WDOG_EVENT_BIT] ##1 1'b1);
    c_bit_test:  cover property (@(posedge ref_clk) soleReq && testIoBitEn ##2 bitValue);
    c_ext_write: cover property (@(posedge ref_clk)
        soleReq && dataWrEn && dataAddr >= iod_pkg::EXT_BASE ##1 1'b1);
    c_io_read:   cover property (@(posedge ref_clk) soleReq && ioRdEn ##2 rdValid);

endmodule // io_register_space_decoder

/* File: tb/iod_low_periph_model.sv */
module iod_low_periph_model (
    // clock
    input  wire logic       ref_clk,
    // strobes from the decoder
    input  wire logic       lowRdEn,
    input  wire logic       lowWrEn,
    input  wire logic [4:0] lowAddr,
    input  wire logic [7:0] lowWrData,
    input  wire logic [7:0] lowWrMask,
    // read path
    output logic      [7:0] lowRdData
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [32];

    initial begin
        for (int i = 0; i < 32; i++) begin
            mem[i] = 8'h00;
        end
    end

    // only bits under the mask change
    always @(posedge ref_clk) begin
        if (lowWrEn === 1'b1) begin
            mem[lowAddr] <= (mem[lowAddr] & ~lowWrMask) | (lowWrData & lowWrMask);
        end
    end

    assign lowRdData = mem[lowAddr];
endmodule // iod_low_periph_model

/* File: tb/io_register_space_decoder_tb.sv */
module io_register_space_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                       ref_clk, srst;
    logic                       ioRdEn, ioWrEn, setIoBitEn, clearIoBitEn, testIoBitEn;
    logic                       dataRdEn, dataWrEn, compEvent, compLevel, wdogEvent;
    logic                       progBusy, rdValid, bitValid, bitValue, lowRdEn, lowWrEn;
    logic [5:0]                 ioAddr;
    logic [4:0]                 bitAddr, lowAddr;
    logic [2:0]                 bitSel;
    logic [3:0]                 resetCause;
    logic [7:0]                 dataAddr, wrData, rdData, lowWrData, lowWrMask, lowRdData;
    logic [7:0]                 rdSeen, exp;
    logic                       bitSeen;
    logic [iod_pkg::NREG*8-1:0] ctlRegs;
    int                         fails, checked, cycCount;

    io_register_space_decoder dut_u (.*);
    iod_low_periph_model periph_u (.ref_clk(ref_clk), .lowRdEn(lowRdEn), .lowWrEn(lowWrEn),
        .lowAddr(lowAddr), .lowWrData(lowWrData), .lowWrMask(lowWrMask),
        .lowRdData(lowRdData));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        if (fails == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycCount++;
        if (cycCount == 5000) begin
            fails++;
            end_sim();
        end
    end

    task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] got);
        checked++;
        if (got !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic cmp1(input string what, input logic e, input logic got);
        checked++;
        if (got !== e) begin
            fails++;
            $display("FAIL %s expected %b seen %b", what, e, got);
        end
    endtask

    // k: 0 data rd, 1 data wr, 2 io rd, 3 io wr, 4 bit set, 5 bit clear, 6 bit test
    task automatic acc(input int k, input logic [7:0] a, input logic [7:0] d,
                       input logic [2:0] s);
        int n;
        @(negedge ref_clk);
        dataAddr = a;
        ioAddr = a[5:0];
        bitAddr = a[4:0];
        wrData = d;
        bitSel = s;
        dataRdEn = (k == 0);
        dataWrEn = (k == 1);
        ioRdEn = (k == 2);
        ioWrEn = (k == 3);
        setIoBitEn = (k == 4);
        clearIoBitEn = (k == 5);
        testIoBitEn = (k == 6);
        @(negedge ref_clk);
        {dataRdEn, dataWrEn, ioRdEn, ioWrEn, setIoBitEn, clearIoBitEn, testIoBitEn} = '0;
        n = 0;
        if (k == 0 || k == 2 || k == 6) begin
            while (rdValid !== 1'b1 && bitValid !== 1'b1 && n < 8) begin
                @(posedge ref_clk);
                #1;
                n++;
            end
            rdSeen = rdData;
            bitSeen = bitValue;
            cmp8("answer latency", 8'h01, 8'(n));
        end else begin
            repeat (2) @(posedge ref_clk);
            #1;
        end
    endtask

    task automatic rd_chk(input int k, input logic [7:0] a, input logic [7:0] e);
        acc(k, a, 8'h00, 3'h0);
        cmp8("read data", e, rdSeen);
    endtask

    initial begin
        {ioRdEn, ioWrEn, setIoBitEn, clearIoBitEn, testIoBitEn, dataRdEn, dataWrEn} = '0;
        {compEvent, compLevel, wdogEvent, progBusy} = '0;
        {ioAddr, bitAddr, bitSel, dataAddr, wrData, resetCause} = '0;
        fails = 0;
        checked = 0;
        cycCount = 0;
        srst = 1'b1;
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        for (int i = 0; i < iod_pkg::NREG; i++) begin
            rd_chk(0, iod_pkg::REG_OFFSET[i], iod_pkg::REG_RESET);
            acc(1, iod_pkg::REG_OFFSET[i],
                iod_pkg::REG_RW_MASK[i] | iod_pkg::REG_W1C_MASK[i], 3'h0);
            rd_chk(0, iod_pkg::REG_OFFSET[i], iod_pkg::REG_RW_MASK[i]);
            cmp8("image", iod_pkg::REG_RW_MASK[i], ctlRegs[8*i+:8]);
        end
        acc(1, 8'h53, 8'hff, 3'h0);
        rd_chk(0, 8'h53, 8'h0f);
        foreach (exp[j]) begin
            rd_chk(0, {8'h4f, 8'h51, 8'h56, 8'h5c, 8'h62, 8'h6a, 8'h71, 8'hff} >> (8 * j),
                8'h00);
        end
        for (int i = 0; i < iod_pkg::NREG; i++) begin
            exp = (8'h5a ^ 8'(i)) & iod_pkg::REG_RW_MASK[i];
            if (iod_pkg::REG_OFFSET[i] < 8'h60) begin
                acc(3, iod_pkg::REG_OFFSET[i] - 8'h20, exp, 3'h0);
                rd_chk(2, iod_pkg::REG_OFFSET[i] - 8'h20, exp);
            end else begin
                acc(1, iod_pkg::REG_OFFSET[i], exp, 3'h0);
            end
            rd_chk(0, iod_pkg::REG_OFFSET[i], exp);
        end
        acc(3, 8'h3f, 8'ha5, 3'h0);
        rd_chk(0, 8'h5f, 8'ha5);
        rd_chk(0, 8'h60, (8'h5a ^ 8'h09) & 8'h7f);
        acc(3, 8'h00, 8'h3c, 3'h0);
        rd_chk(0, 8'h20, 8'h3c);
        acc(1, 8'h25, 8'hc4, 3'h0);
        rd_chk(2, 8'h05, 8'hc4);
        acc(4, 8'h05, 8'h00, 3'h3);
        cmp8("low byte", 8'hcc, periph_u.mem[5]);
        acc(5, 8'h05, 8'h00, 3'h7);
        cmp8("low byte", 8'h4c, periph_u.mem[5]);
        acc(6, 8'h05, 8'h00, 3'h3);
        cmp1("tested bit", 1'b1, bitSeen);
        acc(6, 8'h05, 8'h00, 3'h5);
        cmp1("tested bit", 1'b0, bitSeen);
        acc(3, 8'h1f, 8'h81, 3'h0);
        acc(4, 8'h1f, 8'h00, 3'h1);
        cmp8("top low byte", 8'h83, periph_u.mem[31]);
        cmp8("image", 8'h00, ctlRegs[7:0] ^ (8'h5a & 8'hff));
        acc(1, 8'h50, 8'h00, 3'h0);
        acc(1, 8'h54, 8'h00, 3'h0);
        acc(1, 8'h57, 8'h00, 3'h0);
        acc(1, 8'h60, 8'h00, 3'h0);
        @(negedge ref_clk);
        {compEvent, wdogEvent, resetCause} = {1'b1, 1'b1, 4'h5};
        @(negedge ref_clk);
        {compEvent, wdogEvent, resetCause} = '0;
        rd_chk(0, 8'h54, 8'h05);
        rd_chk(0, 8'h50, 8'h10);
        acc(1, 8'h50, 8'h00, 3'h0);
        rd_chk(0, 8'h50, 8'h10);
        acc(1, 8'h50, 8'h10, 3'h0);
        rd_chk(0, 8'h50, 8'h00);
        acc(1, 8'h60, 8'h00, 3'h0);
        rd_chk(0, 8'h60, 8'h80);
        acc(1, 8'h60, 8'h80, 3'h0);
        rd_chk(0, 8'h60, 8'h00);
        @(negedge ref_clk);
        compLevel = 1'b1;
        progBusy = 1'b1;
        rd_chk(0, 8'h50, 8'h20);
        rd_chk(0, 8'h57, 8'h40);
        end_sim();
    end
endmodule // io_register_space_decoder_tb
